// ==== logic/tpp_defines.vh ====
// constants for the triac phase and potentiometer timer block
`ifndef TPP_DEFINES_VH
`define TPP_DEFINES_VH

// ------------------------------------------------------------
// counter and channel modes
// ------------------------------------------------------------
`define TPP_CNT_W        16
`define TPP_CNT_RST      16'h0000
`define TPP_MODE_CAPTURE 2'h0
`define TPP_MODE_SET     2'h1
`define TPP_MODE_CLEAR   2'h2
`define TPP_MODE_TOGGLE  2'h3

// ------------------------------------------------------------
// firing and conversion figures
// ------------------------------------------------------------
`define TPP_FIRE_PULSES  2'h3
`define TPP_PULSE_NS     10000
`define TPP_CLK_NS       25
`define TPP_PULSE_CYC    ((`TPP_PULSE_NS + `TPP_CLK_NS - 1) / `TPP_CLK_NS)
`define TPP_PRECHG_NS    50000
`define TPP_PRECHG_CYC   ((`TPP_PRECHG_NS + `TPP_CLK_NS - 1) / `TPP_CLK_NS)
`define TPP_STEP_SHIFT   9
`define TPP_POT_SHIFT    8

`endif

// ==== logic/tpp_divider.v ====
// sequential unsigned divider: 24-bit dividend over 16-bit divisor
`timescale 1ns/1ps

module tpp_divider (
    // clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // request
    input  wire        start,
    input  wire [23:0] dividend,
    input  wire [15:0] divisor,
    // answer
    output reg         done_reg,
    output reg  [23:0] quot_reg
);

    // ------------------------------------------------------------
    // restoring division, one quotient bit per clock
    // ------------------------------------------------------------
    reg  [16:0] rem_reg;       // partial remainder
    reg  [15:0] dsr_reg;       // latched divisor
    reg  [4:0]  cnt_reg;       // bits left
    reg         busy_reg;      // division running
    wire [16:0] trial;         // shifted remainder
    wire [16:0] diff;          // trial minus divisor

    assign trial = {rem_reg[15:0], quot_reg[23]};
    assign diff  = trial - {1'b0, dsr_reg};

    // one bit per edge; a zero divisor sets the top 16 quotient bits, caller clamps
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rem_reg  <= 17'h00000;
            dsr_reg  <= 16'h0000;
            cnt_reg  <= 5'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            quot_reg <= 24'h000000;
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg  <= 17'h00000;
                dsr_reg  <= divisor;
                quot_reg <= dividend;
                cnt_reg  <= 5'h18;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                // subtract when it fits, else keep remainder
                if (!diff[16]) begin
                    rem_reg  <= diff;
                    quot_reg <= {quot_reg[22:0], 1'b1};
                end else begin
                    rem_reg  <= trial;
                    quot_reg <= {quot_reg[22:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 5'h01;
                if (cnt_reg == 5'h01) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== logic/tpp_timer.v ====
// triac phase firing and potentiometer single-slope timer
// Function
// - 16-bit free-running upward wrapping counter
// - three channels: capture or set/clear/toggle compare
// - measure, spare and line/fire channel roles
// - each firing is three gate pulses
// - pot measurement starts at zero crossing
// - pot pins drive high, low or release
// - wiper = (wiper-low)*256/(high-low)
// - count until falling sense threshold
// - three terminal measurements run in turn, each after its own precharge and crossing
// - measure channel captures on discharge sense pin
// - gate output active high, rests low
// - each zero-cross edge captures line/fire reference
// - compare at reference plus offset sets gate
// - offset = speed times full cycle / 512
`timescale 1ns/1ps
`include "tpp_defines.vh"

module tpp_timer (
    // clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // software control
    input  wire [7:0]  speed,
    input  wire        fire_enable,
    input  wire        pot_start,
    input  wire [1:0]  spare_mode,
    input  wire [15:0] spare_value,
    // zero-cross detector, discharge sense and spare capture input
    input  wire        zero_cross,
    input  wire        discharge_sense_pin,
    input  wire        spare_in,
    // pot terminals: high, wiper, low (one out and one oe bit each)
    output reg  [2:0]  pot_out_reg,
    output reg  [2:0]  pot_oe_reg,
    // triac gate and spare output
    output reg         gate_reg,
    output reg         spare_out_reg,
    // results
    output reg  [15:0] counter_reg,
    output reg  [15:0] step_reg,
    output reg  [7:0]  pot_value_reg,
    output reg         pot_valid_reg,
    output reg  [15:0] spare_capture_reg
);

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam MS_IDLE = 3'h0;   // waiting for start
    localparam MS_PRE  = 3'h1;   // precharge all terminals
    localparam MS_WAIT = 3'h2;   // wait for zero crossing
    localparam MS_DIS  = 3'h3;   // discharge one terminal
    localparam MS_DIV  = 3'h4;   // ratio division running
    localparam FS_REF  = 2'h0;   // waiting for reference
    localparam FS_CMP  = 2'h1;   // compare armed
    localparam FS_PUL  = 2'h2;   // gate pulse train

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    // wrap-tolerant elapsed counts
    function [15:0] elapsed;
        input [15:0] now_v;
        input [15:0] ref_v;
        begin
            elapsed = now_v - ref_v;
        end
    endfunction

    // one-hot discharge terminal select
    function [2:0] term_onehot;
        input [1:0] idx;
        begin
            term_onehot = 3'h1 << idx;
        end
    endfunction

    // ------------------------------------------------------------
    // free-running counter
    // ------------------------------------------------------------
    wire [15:0] counter_next;
    assign counter_next = counter_reg + 16'h0001;

    // counts every clock, wraps at the top
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            counter_reg <= `TPP_CNT_RST;
        else
            counter_reg <= counter_next;
    end

    // ------------------------------------------------------------
    // edge detection on synchronous inputs
    // ------------------------------------------------------------
    reg  zc_prev_reg;      // zero-cross last level
    reg  sense_prev_reg;   // discharge sense last level
    reg  spare_prev_reg;   // spare input last level
    wire zc_edge;          // any zero-cross edge
    wire sense_fall;       // sense crossed down
    wire spare_rise;       // spare capture event

    assign zc_edge    = zero_cross ^ zc_prev_reg;
    assign sense_fall = sense_prev_reg & ~discharge_sense_pin;
    assign spare_rise = spare_in & ~spare_prev_reg;

    // previous levels for edge finding
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            zc_prev_reg    <= 1'b0;
            sense_prev_reg <= 1'b0;
            spare_prev_reg <= 1'b0;
        end else begin
            zc_prev_reg    <= zero_cross;
            sense_prev_reg <= discharge_sense_pin;
            spare_prev_reg <= spare_in;
        end
    end

    // ------------------------------------------------------------
    // line/fire channel: capture, step, compare, pulse train
    // ------------------------------------------------------------
    reg  [1:0]  fs_reg;        // fire state
    reg  [15:0] zc_ref_reg;    // reference of last crossing
    reg  [15:0] cyc_ref_reg;   // reference two crossings ago
    reg         zc_half_reg;   // toggles each crossing
    reg  [15:0] cmp_reg;       // compare value
    reg  [1:0]  pulse_cnt_reg; // pulses delivered
    reg  [15:0] pw_cnt_reg;    // pulse width and gap timer
    wire [23:0] offset;        // speed times step

    assign offset = {16'h0000, speed} * {8'h00, step_reg};

    // capture on every crossing, then compare and pulse
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fs_reg        <= FS_REF;
            zc_ref_reg    <= 16'h0000;
            cyc_ref_reg   <= 16'h0000;
            zc_half_reg   <= 1'b0;
            step_reg      <= 16'h0000;
            cmp_reg       <= 16'h0000;
            pulse_cnt_reg <= 2'h0;
            pw_cnt_reg    <= 16'h0000;
            gate_reg      <= 1'b0;
        end else begin
            if (zc_edge) begin
                zc_ref_reg  <= counter_reg;
                zc_half_reg <= ~zc_half_reg;
                // full cycle every second crossing
                if (zc_half_reg) begin
                    step_reg    <= elapsed(counter_reg, cyc_ref_reg)
                                   >> `TPP_STEP_SHIFT;
                    cyc_ref_reg <= counter_reg;
                end
                cmp_reg  <= counter_reg + offset[15:0];
                gate_reg <= 1'b0;
                fs_reg   <= fire_enable ? FS_CMP : FS_REF;
            end else begin
                case (fs_reg)
                    FS_CMP: begin
                        // match sets the gate: first pulse
                        if (counter_reg == cmp_reg) begin
                            gate_reg      <= 1'b1;
                            pulse_cnt_reg <= 2'h1;
                            pw_cnt_reg    <= 16'h0000;
                            fs_reg        <= FS_PUL;
                        end
                    end
                    FS_PUL: begin
                        // equal high and low phases, three pulses
                        if (pw_cnt_reg == `TPP_PULSE_CYC - 1) begin
                            pw_cnt_reg <= 16'h0000;
                            if (gate_reg) begin
                                gate_reg <= 1'b0;
                                if (pulse_cnt_reg == `TPP_FIRE_PULSES)
                                    fs_reg <= FS_REF;
                            end else begin
                                gate_reg      <= 1'b1;
                                pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
                            end
                        end else begin
                            pw_cnt_reg <= pw_cnt_reg + 16'h0001;
                        end
                    end
                    default: begin
                        gate_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // spare channel: free capture or compare output
    // ------------------------------------------------------------
    // generic mode kept for other uses
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            spare_capture_reg <= 16'h0000;
            spare_out_reg     <= 1'b0;
        end else begin
            case (spare_mode)
                `TPP_MODE_CAPTURE: begin
                    if (spare_rise)
                        spare_capture_reg <= counter_reg;
                end
                `TPP_MODE_SET: begin
                    if (counter_reg == spare_value)
                        spare_out_reg <= 1'b1;
                end
                `TPP_MODE_CLEAR: begin
                    if (counter_reg == spare_value)
                        spare_out_reg <= 1'b0;
                end
                default: begin
                    if (counter_reg == spare_value)
                        spare_out_reg <= ~spare_out_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // measure channel: single-slope conversion sequencer
    // ------------------------------------------------------------
    reg  [2:0]  ms_reg;            // measure state
    reg  [1:0]  term_reg;          // 0 high, 1 wiper, 2 low
    reg  [15:0] start_reg;         // discharge start count
    reg  [15:0] pre_cnt_reg;       // precharge timer
    reg  [15:0] cnt_hi_reg;        // pot_high_count
    reg  [15:0] cnt_wp_reg;        // pot_wiper_count
    reg  [15:0] div_den_reg;       // high minus low
    reg  [23:0] div_num_reg;       // (wiper minus low) * 256
    reg         div_go_reg;        // divider start pulse
    wire        div_done;          // divider answer
    wire [23:0] div_quot;          // divider quotient
    wire [15:0] meas;              // elapsed discharge counts

    assign meas = elapsed(counter_reg, start_reg);

    // precharge, wait crossing, discharge each terminal, divide
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ms_reg        <= MS_IDLE;
            term_reg      <= 2'h0;
            start_reg     <= 16'h0000;
            pre_cnt_reg   <= 16'h0000;
            cnt_hi_reg    <= 16'h0000;
            cnt_wp_reg    <= 16'h0000;
            div_den_reg   <= 16'h0000;
            div_num_reg   <= 24'h000000;
            div_go_reg    <= 1'b0;
            pot_out_reg   <= 3'h0;
            pot_oe_reg    <= 3'h0;
            pot_value_reg <= 8'h00;
            pot_valid_reg <= 1'b0;
        end else begin
            div_go_reg    <= 1'b0;
            pot_valid_reg <= 1'b0;
            case (ms_reg)
                MS_IDLE: begin
                    pot_oe_reg <= 3'h0;
                    if (pot_start) begin
                        term_reg    <= 2'h0;
                        pre_cnt_reg <= 16'h0000;
                        ms_reg      <= MS_PRE;
                    end
                end
                MS_PRE: begin
                    // all terminals high to charge the capacitor
                    pot_out_reg <= 3'h7;
                    pot_oe_reg  <= 3'h7;
                    if (pre_cnt_reg == `TPP_PRECHG_CYC - 1)
                        ms_reg <= MS_WAIT;
                    else
                        pre_cnt_reg <= pre_cnt_reg + 16'h0001;
                end
                MS_WAIT: begin
                    // same supply point for every conversion
                    if (zc_edge) begin
                        start_reg   <= counter_reg;
                        pot_out_reg <= 3'h0;
                        pot_oe_reg  <= term_onehot(term_reg);
                        ms_reg      <= MS_DIS;
                    end
                end
                MS_DIS: begin
                    // capture on falling sense threshold
                    if (sense_fall) begin
                        case (term_reg)
                            2'h0:    cnt_hi_reg <= meas;
                            2'h1:    cnt_wp_reg <= meas;
                            default: begin
                                div_den_reg <= cnt_hi_reg - meas;
                                div_num_reg <= {cnt_wp_reg - meas, 8'h00};
                            end
                        endcase
                        // next terminal is precharged again and waits for a crossing
                        if (term_reg == 2'h2) begin
                            pot_oe_reg <= 3'h0;
                            div_go_reg <= 1'b1;
                            ms_reg     <= MS_DIV;
                        end else begin
                            term_reg    <= term_reg + 2'h1;
                            pre_cnt_reg <= 16'h0000;
                            ms_reg      <= MS_PRE;
                        end
                    end
                end
                MS_DIV: begin
                    // clamp keeps the result in 0..255
                    if (div_done) begin
                        pot_value_reg <= (div_quot[23:8] != 16'h0000) ? 8'hFF
                                         : div_quot[7:0];
                        pot_valid_reg <= 1'b1;
                        ms_reg        <= MS_IDLE;
                    end
                end
                default: begin
                    ms_reg <= MS_IDLE;
                end
            endcase
        end
    end

    // ratio divider, 24 clocks per result, one quotient bit each
    tpp_divider u_div (
        .clock    (clock),
        .arst_n   (arst_n),
        .start    (div_go_reg),
        .dividend (div_num_reg),
        .divisor  (div_den_reg),
        .done_reg (div_done),
        .quot_reg (div_quot)
    );

endmodule

// ==== tb/tpp_line_pot_model.sv ====
// line zero-cross source and pot rc network for the timer bench
`timescale 1ns/1ps

module tpp_line_pot_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // bench controls
    input  wire logic        zc_run,
    input  wire logic [15:0] half_cyc,
    input  wire logic [15:0] t_hi,
    input  wire logic [15:0] t_wi,
    input  wire logic [15:0] t_lo,
    // pot pins from the timer
    input  wire logic [2:0]  pot_out_reg,
    input  wire logic [2:0]  pot_oe_reg,
    // lines back to the timer
    output logic             zero_cross,
    output logic             discharge_sense_pin
);
    logic [15:0] zc_cnt;   // clocks into this half cycle
    logic [15:0] dis_cnt;  // clocks since discharge began
    logic [15:0] dis_lim;  // discharge time of the open terminal

    // one terminal discharges at a time; pick its time
    always_comb begin
        dis_lim = t_lo;
        if (pot_oe_reg[0]) dis_lim = t_hi;
        else if (pot_oe_reg[1]) dis_lim = t_wi;
    end

    // changes land on the falling edge, clear of the timer's sampling edge
    always @(negedge clock or negedge arst_n) begin
        if (!arst_n) begin
            zc_cnt              <= 16'h0000;
            zero_cross          <= 1'b0;
            dis_cnt             <= 16'h0000;
            discharge_sense_pin <= 1'b0;
        end else begin
            // >= so a shorter half cycle takes effect without a wrap
            if (zc_run && zc_cnt >= half_cyc - 16'h0001) begin
                zc_cnt     <= 16'h0000;
                zero_cross <= ~zero_cross;
            end else if (zc_run) begin
                zc_cnt <= zc_cnt + 16'h0001;
            end
            // capacitor held charged while every pin drives high
            if (pot_oe_reg == 3'h7 && pot_out_reg == 3'h7) begin
                dis_cnt             <= 16'h0000;
                discharge_sense_pin <= 1'b1;
            end else if (pot_oe_reg != 3'h0 && (pot_out_reg & pot_oe_reg) == 3'h0) begin
                dis_cnt <= dis_cnt + 16'h0001;
                if (dis_cnt == dis_lim) discharge_sense_pin <= 1'b0;
            end
        end
    end
endmodule

// ==== tb/tpp_timer_properties.sv ====
// port-level assertion checker for the triac phase and pot timer
`timescale 1ns/1ps
`include "tpp_defines.vh"

module tpp_timer_properties (
    // clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // inputs seen by the timer
    input wire logic        zero_cross,
    input wire logic [1:0]  spare_mode,
    input wire logic [15:0] spare_value,
    // outputs under watch
    input wire logic [2:0]  pot_out_reg,
    input wire logic [2:0]  pot_oe_reg,
    input wire logic        gate_reg,
    input wire logic        spare_out_reg,
    input wire logic [15:0] counter_reg,
    input wire logic        pot_valid_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic        zc_q;      // last sampled crossing level
    logic [15:0] hi_cnt;    // length of the running gate pulse
    logic [15:0] lo_cnt;    // length of the running gate gap
    logic [1:0]  pulse_cnt; // rises since the last crossing
    logic [3:0]  zc_age;    // clocks since a crossing, saturating

    // a crossing restarts the pulse count so aborted trains are not judged
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            zc_q      <= 1'b0;
            hi_cnt    <= 16'h0000;
            lo_cnt    <= 16'h0000;
            pulse_cnt <= 2'h0;
            zc_age    <= 4'hF;
        end else begin
            zc_q   <= zero_cross;
            hi_cnt <= gate_reg ? hi_cnt + 16'h0001 : 16'h0000;
            lo_cnt <= gate_reg ? 16'h0000 : lo_cnt + {15'h0000, lo_cnt != 16'hFFFF};
            zc_age <= (zero_cross != zc_q) ? 4'h0 : zc_age + {3'h0, zc_age != 4'hF};
            if (zero_cross != zc_q) begin
                pulse_cnt <= 2'h0;
            end else if (gate_reg && hi_cnt == 16'h0000 && pulse_cnt != 2'h3) begin
                pulse_cnt <= pulse_cnt + 2'h1;
            end
        end
    end

    property p_cnt_up;
        1'b1 |-> ##2 counter_reg == $past(counter_reg, 2) + 16'h0002;
    endproperty
    a_cnt_up: assert property (p_cnt_up) else $error("counter not stepping by one");
    property p_pulse_len;
        $fell(gate_reg) && zc_age > 4'h1 |-> hi_cnt == `TPP_PULSE_CYC;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("gate pulse length wrong");
    property p_gap_len;
        $rose(gate_reg) && pulse_cnt != 2'h0 |-> lo_cnt == `TPP_PULSE_CYC;
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("gate gap length wrong");
    property p_three;
        $rose(gate_reg) |-> pulse_cnt < 2'h3;
    endproperty
    a_three: assert property (p_three) else $error("more than three gate pulses");
    property p_abort;
        zero_cross != zc_q |=> !gate_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("gate high after crossing");
    property p_pot_drive;
        pot_oe_reg != 3'h0 |-> (pot_oe_reg == 3'h7 && pot_out_reg == 3'h7)
            || ($onehot(pot_oe_reg) && (pot_out_reg & pot_oe_reg) == 3'h0);
    endproperty
    a_pot_drive: assert property (p_pot_drive) else $error("bad pot pin drive");
    property p_dis_zc;
        $onehot(pot_oe_reg) && $past(pot_oe_reg) == 3'h7 |-> zc_age < 4'h3;
    endproperty
    a_dis_zc: assert property (p_dis_zc) else $error("discharge not at crossing");
    property p_valid_one;
        pot_valid_reg |=> !pot_valid_reg;
    endproperty
    a_valid_one: assert property (p_valid_one) else $error("result flag too long");
    property p_spare_set;
        spare_mode == `TPP_MODE_SET && $past(spare_mode) == `TPP_MODE_SET
            && counter_reg == spare_value |-> ##[1:2] spare_out_reg;
    endproperty
    a_spare_set: assert property (p_spare_set) else $error("spare set missed");

    c_train: cover property ($rose(gate_reg) && pulse_cnt == 2'h2);
    c_abort: cover property (zero_cross != zc_q && gate_reg);
    c_valid: cover property (pot_valid_reg);
endmodule

// ==== tb/tpp_timer_test.sv ====
// self-checking bench for the triac phase and pot timer
`timescale 1ns/1ps
`include "tpp_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end

module tpp_timer_test;
    logic        clock, arst_n, fire_enable, pot_start, spare_in, zc_run;
    logic [7:0]  speed;
    logic [1:0]  spare_mode;
    logic [15:0] spare_value, half_cyc, t_wi, c0;
    wire         zero_cross, discharge_sense_pin, gate_reg, spare_out_reg, pot_valid_reg;
    wire  [2:0]  pot_out_reg, pot_oe_reg;
    wire  [15:0] counter_reg, step_reg, spare_capture_reg;
    wire  [7:0]  pot_value_reg;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles = 0;

    tpp_timer tpp_timer_i (
        .clock(clock), .arst_n(arst_n), .speed(speed), .fire_enable(fire_enable),
        .pot_start(pot_start), .spare_mode(spare_mode), .spare_value(spare_value),
        .zero_cross(zero_cross), .discharge_sense_pin(discharge_sense_pin),
        .spare_in(spare_in), .pot_out_reg(pot_out_reg), .pot_oe_reg(pot_oe_reg),
        .gate_reg(gate_reg), .spare_out_reg(spare_out_reg), .counter_reg(counter_reg),
        .step_reg(step_reg), .pot_value_reg(pot_value_reg), .pot_valid_reg(pot_valid_reg),
        .spare_capture_reg(spare_capture_reg));
    tpp_line_pot_model tpp_line_pot_model_i (
        .clock(clock), .arst_n(arst_n), .zc_run(zc_run), .half_cyc(half_cyc),
        .t_hi(16'h04C8), .t_wi(t_wi), .t_lo(16'h00C8), .pot_out_reg(pot_out_reg),
        .pot_oe_reg(pot_oe_reg), .zero_cross(zero_cross),
        .discharge_sense_pin(discharge_sense_pin));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // a hang ends the run as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 98000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one train per crossing; step is 20 with a 5120-clock half cycle
    task automatic fire_chk(input logic [7:0] sp, input logic en, input int n_rise,
                            input int n_hi);
        logic [15:0] ref_c;
        logic        gate_q;
        int          rises;
        int          hi;
        speed = sp;
        fire_enable = en;
        rises = 0;
        hi = 0;
        gate_q = 1'b0;
        @(zero_cross);
        ref_c = counter_reg;
        repeat (2550) begin
            @(negedge clock);
            if (gate_reg === 1'b1 && !gate_q) begin
                rises++;
                if (rises == 1) `CHK(counter_reg, ref_c + sp * 16'h0014 + 16'h0001)
            end
            hi += (gate_reg === 1'b1);
            gate_q = gate_reg;
        end
        `CHK(rises, n_rise)
        `CHK(hi, n_hi)
        @(zero_cross);
        @(negedge clock);
        `CHK(gate_reg, 1'b0)
    endtask

    // set, clear and toggle on match, then a rising capture
    task automatic spare_chk;
        logic [15:0] c;
        for (int m = 1; m < 4; m++) begin
            spare_mode = m[1:0];
            spare_value = counter_reg + 16'h0010;
            repeat (20) @(negedge clock);
            `CHK(spare_out_reg, m[0])
        end
        spare_mode = `TPP_MODE_CAPTURE;
        repeat (2) @(negedge clock);
        c = counter_reg;
        spare_in = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(spare_capture_reg - c <= 16'h0001, 1'b1)
        spare_in = 1'b0;
    endtask

    // low 200, high 1224: result is (wiper - 200) / 4, clamped
    task automatic pot_chk(input logic [15:0] wiper, input logic [7:0] exp_val);
        int n;
        n = 0;
        t_wi = wiper;
        pot_start = 1'b1;
        @(negedge clock);
        pot_start = 1'b0;
        while (pot_valid_reg !== 1'b1 && n < 40000) begin
            @(negedge clock);
            n++;
            pot_start = (n == 50); // a request while busy must be ignored
        end
        `CHK(pot_valid_reg, 1'b1)
        `CHK(pot_value_reg, exp_val)
        repeat (2) @(negedge clock);
        `CHK({pot_oe_reg, pot_valid_reg}, 4'h0)
    endtask

    initial begin
        arst_n = 1'b0;
        speed = 8'h00;
        fire_enable = 1'b0;
        pot_start = 1'b0;
        spare_mode = `TPP_MODE_CAPTURE;
        spare_value = 16'h0000;
        spare_in = 1'b0;
        zc_run = 1'b0;
        half_cyc = 16'h1400;
        t_wi = 16'h00C8;
        repeat (6) @(negedge clock);
        `CHK({gate_reg, pot_oe_reg, pot_valid_reg, counter_reg}, 21'h000000)
        arst_n = 1'b1;
        c0 = counter_reg;
        repeat (100) @(negedge clock);
        `CHK(counter_reg, c0 + 16'h0064)
        spare_chk();
        zc_run = 1'b1;
        repeat (4) @(zero_cross);
        @(negedge clock);
        `CHK(step_reg, 16'h0014)
        fire_chk(8'h01, 1'b1, 3, 1200);
        fire_chk(8'h14, 1'b1, 3, 1200);
        fire_chk(8'h28, 1'b0, 0, 0);
        fire_chk(8'h7D, 1'b1, 1, 50);
        half_cyc = 16'h0258;
        pot_chk(16'h01C8, 8'h40);
        pot_chk(16'h04C8, 8'hFF);
        pot_chk(16'h00C8, 8'h00);
        end_sim();
    end
endmodule

bind tpp_timer tpp_timer_properties tpp_timer_properties_i (
    .clock(clock), .arst_n(arst_n), .zero_cross(zero_cross), .spare_mode(spare_mode),
    .spare_value(spare_value), .pot_out_reg(pot_out_reg), .pot_oe_reg(pot_oe_reg),
    .gate_reg(gate_reg), .spare_out_reg(spare_out_reg), .counter_reg(counter_reg),
    .pot_valid_reg(pot_valid_reg));
